// ==== hdl/global_fault_syndrome_capture.sv ====
// Purpose: Banked global fault syndrome registers with status capture
// Assumes: Fault reports and register port are on i_clk; index 0 non-secure, 1 secure
// Notes: Reset clears to zero as a defined stand-in for unknown values
module global_fault_syndrome_capture
    import gfsyn_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_secure,
    output logic [31:0] o_rdata,
    // Fault reports
    input wire fault_s i_fault,
    // State visible to the rest of the unit
    output logic o_ns_fault_pending,
    output logic o_s_fault_pending
);
    state_s st_q;
    state_s st_d;
    regreq_s req;
    logic bank;
    logic route_ctrl;
    logic [31:0] syn0_new;
    logic [31:0] syn1_new;
    logic [31:0] syn1_rd_mask;
    logic [31:0] rd_val;
    logic [1:0] idx;
    logic alias_hit;
    logic cap_load;
    logic cap_merge;

    assign req = '{wr: i_wr, rd: i_rd, secure: i_secure, addr: i_addr, wdata: i_wdata};
    assign route_ctrl = st_q.control[B_CTRL_ROUTE];

    // Capture qualifiers: a load needs an empty target bank, else the report only merges
    assign cap_load = i_ce && i_fault.valid && (st_q.status[bank] == RESET_VAL);
    assign cap_merge = i_ce && i_fault.valid && (st_q.status[bank] != RESET_VAL);

    // Bank choice for a new fault
    always_comb begin
        bank = i_fault.secure_bank;
        // Non-secure external abort escalated to secure status when routed
        if (i_fault.ext_abort && i_fault.ns_client && route_ctrl) begin
            bank = 1'b1;
        end
    end

    // Syndrome words assembled from the report
    always_comb begin
        syn0_new = RESET_VAL;
        syn0_new[B_OP_ORIGIN] = i_fault.op_origin;
        syn0_new[B_INSTR] = i_fault.instr;
        syn0_new[B_PRIV] = i_fault.priv;
        // Far atomics look like reads to keep the handler's replay logic simple
        syn0_new[B_WRITE] = i_fault.write & ~i_fault.far_atomic;
        if (bank) begin
            syn0_new[B_NS_ATTR] = i_fault.ns_attr;
            syn0_new[B_NS_DEV] = i_fault.ns_client;
        end else begin
            syn0_new[B_NESTED] = i_fault.nested;
        end
        syn1_new = RESET_VAL;
        syn1_new[SSD_LSB +: SSD_W] = i_fault.ssd;
        syn1_new[SID_W-1:0] = i_fault.sid;
        if (!st_q.control[B_CTRL_SSD_PRESENT]) begin
            syn1_new[SSD_LSB +: SSD_W] = '0;
        end
    end

    // Address decode: plain offsets follow the caller's state, aliases reach non-secure
    always_comb begin
        alias_hit = req.secure && (req.addr >= OFF_ALIAS_SYN0) && (req.addr <= OFF_ALIAS_STATUS);
        idx = alias_hit ? 2'(req.addr - OFF_ALIAS_SYN0) : req.addr[1:0];
    end

    // Read mux
    always_comb begin
        logic b;
        b = req.secure && !alias_hit;
        syn1_rd_mask = SYN1_SID_MASK;
        if (req.secure) begin
            syn1_rd_mask = SYN1_SID_MASK | SYN1_SSD_MASK;
        end
        rd_val = RESET_VAL;
        if (req.addr == OFF_CONTROL) begin
            rd_val = req.secure ? st_q.control : RESET_VAL;
        end else if (req.addr <= OFF_STATUS || alias_hit) begin
            unique case (idx)
                2'h0: rd_val = st_q.syn0[b];
                2'h1: rd_val = st_q.syn1[b] & syn1_rd_mask;
                2'h2: rd_val = st_q.syn2[b];
                2'h3: rd_val = st_q.status[b];
            endcase
        end
    end

    // Next state: software writes first, a fault capture overrides them
    always_comb begin
        logic b;
        logic [31:0] m1;
        st_d = st_q;
        b = req.secure && !alias_hit;
        m1 = req.secure ? (SYN1_SID_MASK | SYN1_SSD_MASK) : SYN1_SID_MASK;
        st_d.rdata = req.rd ? rd_val : RESET_VAL;
        if (req.wr) begin
            if (req.addr == OFF_CONTROL && req.secure) begin
                st_d.control = req.wdata & CONTROL_MASK;
            end else if (req.addr <= OFF_STATUS || alias_hit) begin
                unique case (idx)
                    2'h0: st_d.syn0[b] = req.wdata & (b ? SYN0_S_MASK : SYN0_NS_MASK);
                    2'h1: st_d.syn1[b] = (st_q.syn1[b] & ~m1) | (req.wdata & m1);
                    2'h2: st_d.syn2[b] = req.wdata;
                    2'h3: st_d.status[b] = st_q.status[b] & ~(req.wdata & STATUS_MASK);
                endcase
            end
        end
        // Fault capture: status bit set wins over a same-cycle clear
        if (i_fault.valid) begin
            if (st_q.status[bank] != RESET_VAL) begin
                st_d.status[bank][B_MULTI] = 1'b1;
            end else begin
                st_d.status[bank][8:0] = i_fault.kind;
                st_d.syn0[bank] = syn0_new;
                st_d.syn1[bank] = syn1_new;
                st_d.syn2[bank] = i_fault.impl;
            end
            if (st_q.status[bank] != RESET_VAL) begin
                st_d.status[bank][8:0] = st_d.status[bank][8:0] | i_fault.kind;
            end
        end
        // Pending flags are registered so the outputs leave straight from flops
        st_d.pending[0] = |st_d.status[0][8:0];
        st_d.pending[1] = |st_d.status[1][8:0];
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_ns_fault_pending = st_q.pending[0];
    assign o_s_fault_pending = st_q.pending[1];

    // Assertions
    AST_WRITE_READ_ATOMIC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_fault.valid && i_fault.far_atomic && st_q.status[bank] == 0)
        |=> !st_q.syn0[$past(bank)][B_WRITE])
        else $error("far atomic recorded as write");
    AST_ROUTE_SECURE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_fault.valid && i_fault.ext_abort && i_fault.ns_client && route_ctrl
         && st_q.status[1] == 0) |=> st_q.syn0[1][B_NS_DEV])
        else $error("routed abort not captured in secure bank");
    AST_NS_RESERVED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_q.syn0[0][B_NS_ATTR] == 1'b0 && st_q.syn0[0][B_NS_DEV] == 1'b0)
        else $error("reserved bits set in non-secure syndrome");
    AST_S_NESTED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_q.syn0[1][B_NESTED] == 1'b0)
        else $error("nested bit set in secure syndrome");
    AST_NS_INDEX_HIDDEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && !i_secure && i_addr == OFF_SYN1) |=> o_rdata[31:16] == 16'h0000)
        else $error("index visible to non-secure read");
    AST_CLEAR_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_wr && !i_secure && i_addr == OFF_STATUS && !i_fault.valid
         && i_wdata[0]) |=> !st_q.status[0][0])
        else $error("status bit not cleared by write of one");
    AST_SID_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_fault.valid && st_q.status[bank] == 0 && i_fault.kind != '0)
        |=> st_q.syn1[$past(bank)][SID_W-1:0] == $past(i_fault.sid) && st_q.status[$past(bank)] != 0)
        else $error("stream id not captured with status");
    AST_READ_LATENCY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && i_secure && i_addr == OFF_SYN2 && !i_wr && !i_fault.valid)
        |=> o_rdata == st_q.syn2[1])
        else $error("secure read did not return secure bank");

    // Named steps of a capture; a report either loads an empty bank or merges
    sequence seq_capture;
        cap_load;
    endsequence

    sequence seq_merge;
        cap_merge;
    endsequence

    sequence seq_secure_capture;
        cap_load && bank;
    endsequence

    sequence seq_ns_capture;
        cap_load && !bank;
    endsequence

    // Translate-operation origin follows the report
    AST_OP_ORIGIN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture
        |=> st_q.syn0[$past(bank)][B_OP_ORIGIN] == $past(i_fault.op_origin))
        else $error("translate origin bit not captured");

    // Security attribute lands only in the secure bank
    AST_NS_ATTR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_secure_capture
        |=> st_q.syn0[1][B_NS_ATTR] == $past(i_fault.ns_attr))
        else $error("security attribute not captured");

    // Device state lands only in the secure bank
    AST_NS_DEVICE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_secure_capture
        |=> st_q.syn0[1][B_NS_DEV] == $past(i_fault.ns_client))
        else $error("device state not captured");

    // A non-secure client reported on the secure side must be marked as such
    AST_NS_CLIENT_SECURE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_secure_capture ##0 i_fault.ns_client
        |=> st_q.syn0[1][B_NS_DEV])
        else $error("non-secure client not marked");

    // Instruction flag follows the report
    AST_INSTR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture
        |=> st_q.syn0[$past(bank)][B_INSTR] == $past(i_fault.instr))
        else $error("instruction flag not captured");

    // Privilege flag follows the report
    AST_PRIV: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture
        |=> st_q.syn0[$past(bank)][B_PRIV] == $past(i_fault.priv))
        else $error("privilege flag not captured");

    // Write flag follows the report unless the access was a far atomic
    AST_WRITE_BIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture
        |=> st_q.syn0[$past(bank)][B_WRITE] == ($past(i_fault.write) & ~$past(i_fault.far_atomic)))
        else $error("write flag not captured");

    // Nested stage flag lands only in the non-secure bank
    AST_NESTED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_ns_capture
        |=> st_q.syn0[0][B_NESTED] == $past(i_fault.nested))
        else $error("nested flag not captured");

    // A plain non-secure read returns the non-secure copy
    AST_NS_BANK_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && !i_secure && i_addr == OFF_SYN0 && !i_wr && !i_fault.valid)
        |=> o_rdata == st_q.syn0[0])
        else $error("non-secure read used wrong bank");

    // A plain secure read returns the secure copy
    AST_S_BANK_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && i_secure && i_addr == OFF_SYN0 && !i_wr && !i_fault.valid)
        |=> o_rdata == st_q.syn0[1])
        else $error("secure read used wrong bank");

    // Without routing, the report's own security state picks the bank
    AST_BANK_BY_STATE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        cap_load && !(i_fault.ext_abort && i_fault.ns_client && route_ctrl)
        |=> st_q.syn1[$past(i_fault.secure_bank)][SID_W-1:0]
            == $past(i_fault.sid))
        else $error("syndrome one written in wrong bank");

    // Index is taken when the lookup registers are present
    AST_SSD_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture ##0 st_q.control[B_CTRL_SSD_PRESENT]
        |=> st_q.syn1[$past(bank)][SSD_LSB +: SSD_W] == $past(i_fault.ssd))
        else $error("security state index not captured");

    // Unimplemented bits of syndrome one never hold ones
    AST_SYN1_UNUSED_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((st_q.syn1[0] | st_q.syn1[1]) & ~(SYN1_SSD_MASK | SYN1_SID_MASK)) == RESET_VAL)
        else $error("unimplemented syndrome one bits set");

    // Without lookup registers the index is defined as zero rather than left floating
    AST_SSD_ABSENT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture ##0 !st_q.control[B_CTRL_SSD_PRESENT]
        |=> st_q.syn1[$past(bank)][SSD_LSB +: SSD_W] == '0)
        else $error("index captured without lookup registers");

    // Secure alias read shows the non-secure copy with its index
    AST_INDEX_VIA_ALIAS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && i_secure && i_addr == OFF_ALIAS_SYN1 && !i_wr && !i_fault.valid)
        |=> o_rdata == st_q.syn1[0])
        else $error("alias read did not expose the index");

    // Secure alias write reaches the non-secure copy
    AST_ALIAS_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_wr && i_secure && i_addr == OFF_ALIAS_SYN2 && !i_fault.valid)
        |=> st_q.syn2[0] == $past(i_wdata))
        else $error("alias write missed the non-secure copy");

    // Alias offsets are not mapped for non-secure callers
    AST_NS_ALIAS_HIDDEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && !i_secure && i_addr >= OFF_ALIAS_SYN0 && i_addr <= OFF_ALIAS_STATUS)
        |=> o_rdata == RESET_VAL)
        else $error("alias visible to non-secure read");

    // Unmapped offsets read zero
    AST_UNMAPPED_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_rd && i_addr > OFF_CONTROL)
        |=> o_rdata == RESET_VAL)
        else $error("unmapped offset returned data");

    // Read data stands only in the cycle after a read strobe
    AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && !i_rd)
        |=> o_rdata == RESET_VAL)
        else $error("read data outside a read");

    // Clock enable low freezes every register, captures included
    AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_ce
        |=> $stable(st_q))
        else $error("state moved with clock enable low");

    // Implementation-defined word is loaded with the rest
    AST_SYN2_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture
        |=> st_q.syn2[$past(bank)] == $past(i_fault.impl))
        else $error("syndrome two not captured");

    // A report into a busy bank raises the multiple-fault bit
    AST_MULTI_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_merge
        |=> st_q.status[$past(bank)][B_MULTI])
        else $error("multiple fault not flagged");

    // Writing zeros to status leaves it unchanged
    AST_CLEAR_ZERO_KEEPS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_wr && i_addr == OFF_STATUS && i_wdata == RESET_VAL && !i_fault.valid)
        |=> $stable(st_q.status))
        else $error("status changed on write of zero");

    // Pending outputs track the status banks
    AST_PENDING_TRACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_ns_fault_pending == (|st_q.status[0][8:0])
        && o_s_fault_pending == (|st_q.status[1][8:0]))
        else $error("pending flag disagrees with status");

    // Status kind loads in the same cycle as the syndromes
    AST_KIND_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_capture
        |=> st_q.status[$past(bank)][8:0] == $past(i_fault.kind))
        else $error("status kind not loaded with syndromes");

    // A merged report must not disturb the syndromes of the first fault
    AST_MERGE_KEEPS_SYN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_merge ##0 !i_wr
        |=> $stable(st_q.syn0))
        else $error("second fault overwrote syndromes");
endmodule : global_fault_syndrome_capture

// ==== hdl/gfsyn_pkg.sv ====
// Purpose: Constants and carrier types for the global fault syndrome capture bank
// Assumes: Register port with one-cycle read latency, 32-bit data
// Notes: Offsets are word indices on the plain register port
package gfsyn_pkg;
    localparam int ADDR_W = 4;
    // Register offsets (word index); bank chosen by the access security state
    localparam logic [ADDR_W-1:0] OFF_SYN0 = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_SYN1 = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_SYN2 = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h3;
    // Secure aliases reaching the non-secure copies
    localparam logic [ADDR_W-1:0] OFF_ALIAS_SYN0 = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_ALIAS_SYN1 = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_ALIAS_SYN2 = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_ALIAS_STATUS = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h8;
    // Syndrome zero field positions
    localparam int B_OP_ORIGIN = 6;
    localparam int B_NS_ATTR = 5;
    localparam int B_NS_DEV = 4;
    localparam int B_INSTR = 3;
    localparam int B_PRIV = 2;
    localparam int B_WRITE = 1;
    localparam int B_NESTED = 0;
    localparam logic [31:0] SYN0_NS_MASK = 32'h0000FF4F;
    localparam logic [31:0] SYN0_S_MASK = 32'h0000FF7E;
    // Implemented widths of syndrome one fields
    localparam int SSD_W = 8;
    localparam int SID_W = 10;
    localparam int SSD_LSB = 16;
    localparam logic [31:0] SYN1_SSD_MASK = 32'h00FF0000;
    localparam logic [31:0] SYN1_SID_MASK = 32'h000003FF;
    // Status and control fields
    localparam int B_CTRL_ROUTE = 0;
    localparam int B_CTRL_SSD_PRESENT = 1;
    localparam logic [31:0] CONTROL_MASK = 32'h00000003;
    localparam logic [31:0] STATUS_MASK = 32'h800001FF;
    localparam int B_MULTI = 31;
    localparam logic [31:0] RESET_VAL = 32'h00000000;

    // Fault report from the translation logic
    typedef struct packed {
        logic valid;
        logic [8:0] kind;
        logic secure_bank;
        logic op_origin;
        logic ns_attr;
        logic ns_client;
        logic ext_abort;
        logic instr;
        logic priv;
        logic write;
        logic far_atomic;
        logic nested;
        logic [SSD_W-1:0] ssd;
        logic [SID_W-1:0] sid;
        logic [31:0] impl;
    } fault_s;

    // Register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic secure;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } regreq_s;

    typedef struct packed {
        logic [1:0][31:0] syn0;
        logic [1:0][31:0] syn1;
        logic [1:0][31:0] syn2;
        logic [1:0][31:0] status;
        logic [31:0] control;
        logic [31:0] rdata;
        logic [1:0] pending;
    } state_s;
endpackage : gfsyn_pkg

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the global fault syndrome capture bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Expected read data is queued by the driver and drained by a monitor
module tb_top
    import gfsyn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [31:0] S0M = 32'hFFFF00FF;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_secure = 1'b0;
    fault_s i_fault = '0;
    logic [31:0] o_rdata;
    logic o_ns_fault_pending;
    logic o_s_fault_pending;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic rd_p = 1'b0;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    fault_s f;
    logic [31:0] e0;
    logic [31:0] d;
    logic [8:0] k1;

    // Clock, 25 MHz
    always #20 i_clk = ~i_clk;

    global_fault_syndrome_capture u_global_fault_syndrome_capture (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_secure(i_secure), .o_rdata(o_rdata), .i_fault(i_fault),
        .o_ns_fault_pending(o_ns_fault_pending), .o_s_fault_pending(o_s_fault_pending));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Every task drives every request and fault input each cycle, so strobes never linger
    task automatic drive(input logic w, input logic r, input logic s,
                         input logic [ADDR_W-1:0] a, input logic [31:0] wd, input fault_s fv);
        @(posedge i_clk);
        i_wr <= w;
        i_rd <= r;
        i_secure <= s;
        i_addr <= a;
        i_wdata <= wd;
        i_fault <= fv;
    endtask : drive

    task automatic wr(input logic s, input logic [ADDR_W-1:0] a, input logic [31:0] v);
        drive(1'b1, 1'b0, s, a, v, '0);
    endtask : wr

    task automatic rd(input logic s, input logic [ADDR_W-1:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        drive(1'b0, 1'b1, s, a, '0, '0);
    endtask : rd

    task automatic idle();
        drive(1'b0, 1'b0, 1'b0, '0, '0, '0);
    endtask : idle

    // Attribute bits as the bank should show them; reserved bits differ per bank
    function automatic logic [31:0] syn0_of(input fault_s x, input logic sec);
        logic [31:0] v;
        v = {25'h0, x.op_origin, x.ns_attr, x.ns_client, x.instr, x.priv,
             x.write & ~x.far_atomic, x.nested};
        return v & (sec ? 32'h0000007E : 32'h0000004F);
    endfunction : syn0_of

    function automatic fault_s rnd_fault(input logic sec);
        logic [95:0] r;
        fault_s x;
        r = {$urandom, $urandom, $urandom};
        x = r[$bits(fault_s)-1:0];
        x.valid = 1'b1;
        x.kind[0] = 1'b1;
        x.secure_bank = sec;
        x.ext_abort = 1'b0;
        return x;
    endfunction : rnd_fault

    // Read data is valid the cycle after the strobe; the flag is delayed once
    always @(posedge i_clk) rd_p <= i_rd;
    always @(negedge i_clk) begin
        if (rd_p) begin
            check(o_rdata & msk_q.pop_front(), exp_q.pop_front());
        end else begin
            check(o_rdata, 32'h0);
        end
    end

    // Hang guard; the whole run needs under 150 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'h7C0D2057));
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        // Reset values, reserved bits, banking and aliases
        rd(1'b0, OFF_SYN0, 32'h0, ALL);
        rd(1'b1, OFF_STATUS, 32'h0, ALL);
        wr(1'b0, OFF_SYN0, ALL);
        wr(1'b1, OFF_SYN0, ALL);
        wr(1'b0, OFF_SYN1, ALL);
        rd(1'b0, OFF_SYN0, 32'h0000FF4F, ALL);
        rd(1'b1, OFF_SYN0, 32'h0000FF7E, ALL);
        rd(1'b1, OFF_ALIAS_SYN1, 32'h000003FF, ALL);
        wr(1'b1, OFF_ALIAS_SYN1, ALL);
        rd(1'b1, OFF_ALIAS_SYN1, 32'h00FF03FF, ALL);
        rd(1'b0, OFF_SYN1, 32'h000003FF, ALL);
        d = $urandom;
        wr(1'b1, OFF_SYN2, d);
        wr(1'b0, OFF_SYN2, ~d);
        rd(1'b1, OFF_SYN2, d, ALL);
        rd(1'b1, OFF_ALIAS_SYN2, ~d, ALL);
        rd(1'b0, OFF_ALIAS_SYN2, 32'h0, ALL);
        rd(1'b0, 4'h9, 32'h0, ALL);
        wr(1'b1, OFF_CONTROL, 32'h00000002);
        wr(1'b0, OFF_CONTROL, 32'h0);
        rd(1'b1, OFF_CONTROL, 32'h00000002, ALL);
        rd(1'b0, OFF_CONTROL, 32'h0, ALL);
        idle();
        $display("test registers done");
        // Clock enable low: a write and a fault are both ignored
        idle();
        i_ce <= 1'b0;
        wr(1'b1, OFF_SYN2, ~d);
        f = rnd_fault(1'b1);
        drive(1'b0, 1'b0, 1'b0, '0, '0, f);
        idle();
        i_ce <= 1'b1;
        rd(1'b1, OFF_SYN2, d, ALL);
        rd(1'b1, OFF_STATUS, 32'h0, ALL);
        $display("test clock enable done");
        // Random faults alternating banks, then clear by writing ones
        for (int k = 0; k < 8; k++) begin
            f = rnd_fault(k[0]);
            f.far_atomic = k[1];
            f.write = f.write | k[2];
            drive(1'b0, 1'b0, 1'b0, '0, '0, f);
            rd(k[0], OFF_SYN0, syn0_of(f, k[0]), S0M);
            rd(k[0], OFF_SYN1, {8'h0, k[0] ? f.ssd : 8'h0, 6'h0, f.sid}, ALL);
            rd(1'b1, k[0] ? OFF_SYN1 : OFF_ALIAS_SYN1, {8'h0, f.ssd, 6'h0, f.sid}, ALL);
            rd(k[0], OFF_SYN2, f.impl, ALL);
            wr(k[0], OFF_STATUS, 32'h0);
            rd(k[0], OFF_STATUS, {23'h0, f.kind}, ALL);
            idle();
            #1;
            check({31'h0, o_s_fault_pending}, {31'h0, k[0]});
            check({31'h0, o_ns_fault_pending}, {31'h0, ~k[0]});
            wr(k[0], OFF_STATUS, ALL);
            rd(k[0], OFF_STATUS, 32'h0, ALL);
        end
        $display("test capture done");
        // External abort of a non-secure client routed to the secure bank, then a second fault
        wr(1'b1, OFF_CONTROL, 32'h00000003);
        f = rnd_fault(1'b0);
        f.ns_client = 1'b1;
        f.ext_abort = 1'b1;
        k1 = f.kind;
        e0 = syn0_of(f, 1'b1);
        drive(1'b0, 1'b0, 1'b0, '0, '0, f);
        f = rnd_fault(1'b1);
        drive(1'b0, 1'b0, 1'b0, '0, '0, f);
        rd(1'b1, OFF_SYN0, e0, S0M);
        rd(1'b1, OFF_STATUS, {1'b1, 22'h0, k1 | f.kind}, ALL);
        rd(1'b1, OFF_ALIAS_STATUS, 32'h0, ALL);
        repeat (3) idle();
        #1;
        check({31'h0, o_s_fault_pending}, 32'h00000001);
        $display("test routing done");
        // Mid-run reset clears both banks and the pending flags
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(1'b1, OFF_STATUS, 32'h0, ALL);
        rd(1'b1, OFF_SYN0, 32'h0, ALL);
        idle();
        #1;
        check({30'h0, o_s_fault_pending, o_ns_fault_pending}, 32'h0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb_top
